// ### src/lafh_top.sv
// top of the line alarm filter handler: detection, filtering, contacts, cut-off, APB slave
//
// Chosen here: the register offsets and the APB register port.
`default_nettype none
// Functional notes
// R1: red held 2-3 s raises carrier red, trunk conditioning, sends remote warning.
// R2: carrier red in drop/insert mode also sends all-ones downstream.
// R3: remote warning held 2-3 s raises carrier warning alarm and trunk conditioning.
// R4: blue signal from remote or intermediate equipment raises the AIS alarm.
// R5: error rate above programmed threshold raises error rate alarm.
// R6: voice signaling transitions or data errors on active port raise port fault.
// R7: any restart raises the system reset alarm.
// R8: loss of primary or secondary timing source raises clock sync alarm.
// R9: report filter forwards remotely, displays and logs the alarm.
// R10: log filter displays and logs, no remote forwarding.
// R11: ignore filter discards the alarm: no display, log, report or contact.
// R12: each alarm carries severity info, minor, major or critical on display and log.
// R13: critical alarm closes one contact, major alarm closes another contact.
// R14: cut-off filter log/report plus major non-ignored alarm makes cut-off alarm.
// R15: minor alarms never make the cut-off alarm.
// R16: latched cut-off holds after the cause clears until operator clears it.
// R17: current mode cut-off follows only presently active conditions.
// R18: cut-off filter ignore means no cut-off alarm at all.
// R19: cut-off drives an external indicator held until operator clears it.
// R20: filter outranks severity; ignored alarms take no severity action.
// R21: red condition is loss of line signal or loss of frame alignment.
// R22: persistence uses one fixed timer, restarting whenever condition drops.
module lafh_top #(
  parameter int unsigned PERSIST_CYCLES = lafh_pkg::PERSIST_CYCLES
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic no_signal,
  input wire logic frame_sync_missing,
  input wire logic remote_warn_indication,
  input wire logic blue_alarm_detect,
  input wire logic [15:0] error_rate,
  input wire logic voice_transition_excess,
  input wire logic data_error_excess,
  input wire logic primary_clk_lost,
  input wire logic secondary_clk_lost,
  output logic carrier_red_alarm,
  output logic carrier_remote_warn_alarm,
  output logic trunk_cond_active,
  output logic [3:0] trunk_conditioning_setting,
  output logic tx_remote_warn,
  output logic tx_ais,
  output logic [7:0] display_active,
  output lafh_pkg::lafh_event_t alarm_event,
  output logic critical_contact,
  output logic major_contact,
  output logic cutoff_indicator
);
  // ==========================================================
  // state
  typedef struct packed {
    lafh_pkg::lafh_cfg_t cfg;
    logic latch_mode;
    logic drop_insert;
    logic [3:0] tc_code;
    logic [15:0] thresh;
    logic booted;
    logic rst_alarm;
    logic [7:0] alarm;
    logic [7:0] display;
    logic [7:0] pending;
    logic cutoff;
    lafh_pkg::lafh_event_t evt;
    lafh_pkg::lafh_event_t last_evt;
    logic crit;
    logic major;
    logic tc_active;
    logic tx_warn;
    logic tx_ais;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } lafh_state_t;

  lafh_state_t st_ff;
  lafh_state_t nxt_st;
  logic red_q;
  logic warn_q;

  // ==========================================================
  // helpers
  function automatic logic passes(input lafh_pkg::lafh_alarm_cfg_t c);
    passes = (c.filter != lafh_pkg::FLT_IGNORE);
  endfunction : passes

  function automatic logic [7:0] sev_mask(input lafh_pkg::lafh_cfg_t c,
                                          input lafh_pkg::lafh_sev_t s);
    logic [7:0] m;
    m = '0;
    for (int i = 0; i < lafh_pkg::NUM_ALARMS; i++)
      m[i] = passes(c[i]) && (c[i].sev == s);
    sev_mask = m;
  endfunction : sev_mask

  function automatic logic [7:0] pass_mask(input lafh_pkg::lafh_cfg_t c);
    logic [7:0] m;
    m = '0;
    for (int i = 0; i < lafh_pkg::NUM_ALARMS; i++)
      m[i] = passes(c[i]);
    pass_mask = m;
  endfunction : pass_mask

  function automatic logic [2:0] lowest(input logic [7:0] v);
    logic [2:0] idx;
    idx = '0;
    for (int i = lafh_pkg::NUM_ALARMS - 1; i >= 0; i--)
      if (v[i])
        idx = 3'(i);
    lowest = idx;
  endfunction : lowest

  // ==========================================================
  // persistence qualifiers
  lafh_persist #(
    .CYCLES(PERSIST_CYCLES)
  ) u_red_persist (
    .pclk(pclk),
    .presetn(presetn),
    .ce(ce),
    .cond(no_signal | frame_sync_missing), // R21
    .qual(red_q)
  );

  lafh_persist #(
    .CYCLES(PERSIST_CYCLES)
  ) u_warn_persist (
    .pclk(pclk),
    .presetn(presetn),
    .ce(ce),
    .cond(remote_warn_indication),
    .qual(warn_q)
  );

  // ==========================================================
  // next state
  logic access;
  logic wr_commit;
  logic [7:0] raw;
  logic [7:0] pass;
  logic [7:0] rise;
  logic [7:0] grant;
  logic cut_trig;
  logic cut_clr;
  logic [2:0] gid;
  logic [7:0] maj_m;

  always_comb
  begin
    nxt_st = st_ff;
    access = psel && penable;
    wr_commit = access && st_ff.pready && pwrite;
    pass = pass_mask(st_ff.cfg);
    raw = '0;
    rise = '0;
    grant = '0;
    cut_trig = 1'b0;
    cut_clr = 1'b0;
    gid = '0;
    maj_m = sev_mask(st_ff.cfg, lafh_pkg::SEV_MAJOR);
    if (ce)
    begin
      // restart is seen once, on the first enabled cycle after reset
      if (!st_ff.booted)
      begin
        nxt_st.booted = 1'b1;
        nxt_st.rst_alarm = 1'b1; // R7
      end

      // cut-off: major alarms only, never minor, gated by its own filter
      cut_trig = (|(st_ff.alarm[6:0] & maj_m[6:0])) // R14 R15 R20
                 && passes(st_ff.cfg[lafh_pkg::AL_CUTOFF]); // R18

      raw[lafh_pkg::AL_RED] = red_q; // R1
      raw[lafh_pkg::AL_WARN] = warn_q; // R3
      raw[lafh_pkg::AL_AIS] = blue_alarm_detect; // R4
      raw[lafh_pkg::AL_ERR] = (error_rate > st_ff.thresh); // R5
      raw[lafh_pkg::AL_PORT] = voice_transition_excess | data_error_excess; // R6
      raw[lafh_pkg::AL_RESET] = st_ff.rst_alarm; // R7
      raw[lafh_pkg::AL_SYNC] = primary_clk_lost | secondary_clk_lost; // R8
      raw[lafh_pkg::AL_CUTOFF] = st_ff.cutoff;
      nxt_st.alarm = raw;
      nxt_st.display = raw & pass; // R11 R20

      // line actions follow the qualified conditions directly
      nxt_st.tc_active = red_q | warn_q; // R1 R3
      nxt_st.tx_warn = red_q; // R1
      nxt_st.tx_ais = red_q && st_ff.drop_insert; // R2

      // contacts from non-ignored alarms only
      nxt_st.crit = |(st_ff.alarm & sev_mask(st_ff.cfg, lafh_pkg::SEV_CRITICAL)); // R13 R20
      nxt_st.major = |(st_ff.alarm & sev_mask(st_ff.cfg, lafh_pkg::SEV_MAJOR)); // R13 R20

      // event stream: one occurrence per cycle, lowest index first
      rise = raw & ~st_ff.alarm & pass; // R11
      nxt_st.evt = '0;
      if (|st_ff.pending)
      begin
        gid = lowest(st_ff.pending);
        grant[gid] = 1'b1;
        nxt_st.evt.valid = 1'b1; // R10
        nxt_st.evt.id = gid;
        nxt_st.evt.sev = st_ff.cfg[gid].sev; // R12
        nxt_st.evt.report = (st_ff.cfg[gid].filter == lafh_pkg::FLT_REPORT); // R9
        nxt_st.last_evt = nxt_st.evt;
      end
      // a new rise wins over the grant that retires it
      nxt_st.pending = (st_ff.pending & ~grant) | rise;

      // ------------------------------------------------------
      // apb
      nxt_st.pready = access && !st_ff.pready;
      if (access && !st_ff.pready)
      begin
        nxt_st.pslverr = 1'b0;
        nxt_st.prdata = '0;
        case (paddr)
          lafh_pkg::OFF_CFG: nxt_st.prdata = st_ff.cfg;
          lafh_pkg::OFF_CTRL:
          begin
            nxt_st.prdata[lafh_pkg::CTRL_LATCH] = st_ff.latch_mode;
            nxt_st.prdata[lafh_pkg::CTRL_DROP_INSERT] = st_ff.drop_insert;
            nxt_st.prdata[lafh_pkg::CTRL_TC_LSB +: 4] = st_ff.tc_code;
          end
          lafh_pkg::OFF_THRESH: nxt_st.prdata[15:0] = st_ff.thresh;
          lafh_pkg::OFF_STATUS: nxt_st.prdata[15:0] = {st_ff.display, st_ff.alarm};
          lafh_pkg::OFF_EVENT: nxt_st.prdata[6:0] = st_ff.last_evt;
          lafh_pkg::OFF_ID: nxt_st.prdata = lafh_pkg::DEVICE_ID;
          default: nxt_st.pslverr = 1'b1;
        endcase
      end
      else if (!access)
      begin
        nxt_st.pslverr = 1'b0;
      end

      if (wr_commit)
      begin
        case (paddr)
          lafh_pkg::OFF_CFG: nxt_st.cfg = pwdata;
          lafh_pkg::OFF_CTRL:
          begin
            nxt_st.latch_mode = pwdata[lafh_pkg::CTRL_LATCH];
            nxt_st.drop_insert = pwdata[lafh_pkg::CTRL_DROP_INSERT];
            nxt_st.tc_code = pwdata[lafh_pkg::CTRL_TC_LSB +: 4];
            cut_clr = pwdata[lafh_pkg::CTRL_CUT_CLEAR];
            if (pwdata[lafh_pkg::CTRL_RST_CLEAR] && st_ff.booted)
              nxt_st.rst_alarm = 1'b0;
          end
          lafh_pkg::OFF_THRESH: nxt_st.thresh = pwdata[15:0];
          default: ;
        endcase
      end

      // cut-off hold: set wins over operator clear
      if (!passes(st_ff.cfg[lafh_pkg::AL_CUTOFF]))
        nxt_st.cutoff = 1'b0; // R18
      else if (st_ff.latch_mode)
        nxt_st.cutoff = cut_trig | (st_ff.cutoff & ~cut_clr); // R16 R19
      else
        nxt_st.cutoff = cut_trig; // R17
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      st_ff <= '0;
      st_ff.cfg <= lafh_pkg::CFG_RESET;
      st_ff.latch_mode <= 1'b1;
      st_ff.thresh <= lafh_pkg::THRESH_RESET;
      st_ff.tc_code <= lafh_pkg::TC_RESET;
    end
    else
      st_ff <= nxt_st;
  end

  // ==========================================================
  // outputs
  assign prdata = st_ff.prdata;
  assign pready = st_ff.pready;
  assign pslverr = st_ff.pslverr;
  assign carrier_red_alarm = st_ff.alarm[lafh_pkg::AL_RED];
  assign carrier_remote_warn_alarm = st_ff.alarm[lafh_pkg::AL_WARN];
  assign trunk_cond_active = st_ff.tc_active;
  assign trunk_conditioning_setting = st_ff.tc_code;
  assign tx_remote_warn = st_ff.tx_warn;
  assign tx_ais = st_ff.tx_ais;
  assign display_active = st_ff.display;
  assign alarm_event = st_ff.evt;
  assign critical_contact = st_ff.crit;
  assign major_contact = st_ff.major;
  assign cutoff_indicator = st_ff.cutoff;

  // ==========================================================
  // checks
  a_red_warn_tx: assert property (@(posedge pclk) disable iff (!presetn)
    (ce && red_q) |=> tx_remote_warn && trunk_cond_active) // R1
    else $error("red qualified without warning and conditioning");
  a_ais_drop_ins: assert property (@(posedge pclk) disable iff (!presetn)
    ce |=> (tx_ais == ($past(red_q) && $past(st_ff.drop_insert)))) // R2
    else $error("all-ones output disagrees with red and drop/insert");
  a_warn_cond: assert property (@(posedge pclk) disable iff (!presetn)
    (ce && warn_q) |=> carrier_remote_warn_alarm) // R3
    else $error("remote warning qualified but alarm missing");
  a_ignore_quiet: assert property (@(posedge pclk) disable iff (!presetn)
    alarm_event.valid |-> st_ff.cfg[alarm_event.id].filter != lafh_pkg::FLT_IGNORE
    || $past(st_ff.cfg[alarm_event.id].filter) != lafh_pkg::FLT_IGNORE) // R11
    else $error("event raised for an ignored alarm");
  a_report_flag: assert property (@(posedge pclk) disable iff (!presetn)
    (ce && |st_ff.pending) |=> alarm_event.valid && alarm_event.report ==
    ($past(st_ff.cfg[lowest(st_ff.pending)].filter) == lafh_pkg::FLT_REPORT)) // R9 R10
    else $error("event report flag does not match filter");
  a_display_pass: assert property (@(posedge pclk) disable iff (!presetn)
    ce |=> (display_active == (st_ff.alarm & $past(pass)))) // R10 R11
    else $error("display disagrees with active alarms and their filters");
  a_cut_ignore: assert property (@(posedge pclk) disable iff (!presetn)
    (ce && !passes(st_ff.cfg[lafh_pkg::AL_CUTOFF])) |=> !cutoff_indicator) // R18
    else $error("cut-off set while its filter ignores");
  a_cut_latched: assert property (@(posedge pclk) disable iff (!presetn)
    (ce && cutoff_indicator && st_ff.latch_mode && !cut_clr
     && passes(st_ff.cfg[lafh_pkg::AL_CUTOFF])) |=> cutoff_indicator) // R16 R19
    else $error("latched cut-off dropped without a clear");
  a_cut_current: assert property (@(posedge pclk) disable iff (!presetn)
    (ce && !st_ff.latch_mode) |=> (cutoff_indicator == $past(cut_trig))) // R17 R15
    else $error("current mode cut-off does not follow its cause");
  a_crit_contact: assert property (@(posedge pclk) disable iff (!presetn)
    ce |=> critical_contact ==
    |($past(st_ff.alarm) & $past(sev_mask(st_ff.cfg, lafh_pkg::SEV_CRITICAL)))) // R13 R20
    else $error("critical contact disagrees with active critical alarms");
  a_reset_alarm: assert property (@(posedge pclk) disable iff (!presetn)
    (ce && !st_ff.booted) |=> ##1 (st_ff.alarm[lafh_pkg::AL_RESET] || !ce)) // R7
    else $error("restart did not raise the reset alarm");
endmodule : lafh_top
`default_nettype wire

// ### src/lafh_pkg.sv
// package: constants, register map and carrier types of the line alarm filter handler
`default_nettype none
package lafh_pkg;
  // ==========================================================
  // timing
  localparam int unsigned CLK_HZ = 40_000_000;
  localparam int unsigned PERSIST_MS = 2500;
  localparam int unsigned PERSIST_CYCLES = PERSIST_MS * (CLK_HZ / 1000);
  localparam int unsigned PERSIST_W = 27;

  // ==========================================================
  // register map (byte addresses)
  localparam logic [7:0] OFF_CFG = 8'h00;
  localparam logic [7:0] OFF_CTRL = 8'h04;
  localparam logic [7:0] OFF_THRESH = 8'h08;
  localparam logic [7:0] OFF_STATUS = 8'h0C;
  localparam logic [7:0] OFF_EVENT = 8'h10;
  localparam logic [7:0] OFF_ID = 8'h14;
  // arbitrary neutral value
  localparam logic [31:0] DEVICE_ID = 32'h0000_A1F0;

  // ctrl fields
  localparam int CTRL_LATCH = 0;
  localparam int CTRL_DROP_INSERT = 1;
  localparam int CTRL_CUT_CLEAR = 2;
  localparam int CTRL_RST_CLEAR = 3;
  localparam int CTRL_TC_LSB = 4;

  // ==========================================================
  // alarm indices
  localparam int NUM_ALARMS = 8;
  localparam logic [2:0] AL_RED = 3'h0;
  localparam logic [2:0] AL_WARN = 3'h1;
  localparam logic [2:0] AL_AIS = 3'h2;
  localparam logic [2:0] AL_ERR = 3'h3;
  localparam logic [2:0] AL_PORT = 3'h4;
  localparam logic [2:0] AL_RESET = 3'h5;
  localparam logic [2:0] AL_SYNC = 3'h6;
  localparam logic [2:0] AL_CUTOFF = 3'h7;

  typedef enum logic [1:0] {
    FLT_IGNORE = 2'h0,
    FLT_LOG = 2'h1,
    FLT_REPORT = 2'h2
  } lafh_filter_t;

  typedef enum logic [1:0] {
    SEV_INFO = 2'h0,
    SEV_MINOR = 2'h1,
    SEV_MAJOR = 2'h2,
    SEV_CRITICAL = 2'h3
  } lafh_sev_t;

  typedef struct packed {
    lafh_sev_t sev;
    lafh_filter_t filter;
  } lafh_alarm_cfg_t;

  typedef lafh_alarm_cfg_t [NUM_ALARMS-1:0] lafh_cfg_t;

  // every alarm log/minor, cut-off entry log/major after reset
  localparam logic [31:0] CFG_RESET = 32'h9555_5555;
  localparam logic [15:0] THRESH_RESET = 16'h0100;
  localparam logic [3:0] TC_RESET = 4'h0;

  typedef struct packed {
    logic valid;
    logic report;
    logic [2:0] id;
    lafh_sev_t sev;
  } lafh_event_t;

  typedef struct packed {
    logic [PERSIST_W-1:0] cnt;
    logic qual;
  } lafh_persist_t;
endpackage : lafh_pkg
`default_nettype wire

// ### src/lafh_persist.sv
// persistence qualifier: a condition must hold for a fixed time before it counts
`default_nettype none
module lafh_persist #(
  parameter int unsigned CYCLES = lafh_pkg::PERSIST_CYCLES
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic cond,
  output logic qual
);
  lafh_pkg::lafh_persist_t st_ff;
  lafh_pkg::lafh_persist_t nxt_st;
  localparam logic [lafh_pkg::PERSIST_W-1:0] LAST = lafh_pkg::PERSIST_W'(CYCLES - 1);

  always_comb
  begin
    nxt_st = st_ff;
    if (ce)
    begin
      if (!cond)
      begin
        // restart from zero on any drop
        nxt_st.cnt = '0; // R22
        nxt_st.qual = 1'b0;
      end
      else if (st_ff.cnt == LAST)
        nxt_st.qual = 1'b1; // R22
      else
        nxt_st.cnt = st_ff.cnt + 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      st_ff <= '0;
    else
      st_ff <= nxt_st;
  end

  assign qual = st_ff.qual;

  a_drop_clears: assert property (@(posedge pclk) disable iff (!presetn)
    (ce && !cond) |=> !qual) // R22
    else $error("qualified flag survived a dropped condition");
  a_rise_needs_cond: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(qual) |-> ($past(cond) && st_ff.cnt == LAST)) // R22
    else $error("qualified rose without full persistence");
endmodule : lafh_persist
`default_nettype wire

// ### verif/lafh_line_model.sv
// far-end model: remote line equipment and timing sources seen by the handler
`default_nettype none
module lafh_line_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [7:0] req,
  output logic no_signal,
  output logic frame_sync_missing,
  output logic remote_warn_indication,
  output logic blue_alarm_detect,
  output logic voice_transition_excess,
  output logic data_error_excess,
  output logic primary_clk_lost,
  output logic secondary_clk_lost
);
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================================
  // line conditions change only just after a clock edge
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      {secondary_clk_lost, primary_clk_lost, data_error_excess, voice_transition_excess,
       blue_alarm_detect, remote_warn_indication, frame_sync_missing, no_signal} <= 8'h00;
    end
    else
    begin
      {secondary_clk_lost, primary_clk_lost, data_error_excess, voice_transition_excess,
       blue_alarm_detect, remote_warn_indication, frame_sync_missing, no_signal} <= req;
    end
  end
endmodule : lafh_line_model
`default_nettype wire

// ### verif/lafh_top_tb.sv
// self-checking bench of the line alarm filter handler
`default_nettype none
`define CHK(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin error_cnt++; \
  $display("ERROR %s exp %h got %h", nm, e, g); end end
module lafh_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct {logic [31:0] d; logic [31:0] m; logic e;} lafh_note_t;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic ce = 1'b1;
  logic [7:0] paddr = 8'h00, req = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, cfg_v;
  logic [15:0] error_rate = 16'h0000;
  logic pready, pslverr, ns, fs, rw, bl, vt, de, pl, sl;
  logic red, warn, tca, txw, txa, crit, maj, cut;
  logic [3:0] tcs;
  logic [7:0] disp;
  lafh_pkg::lafh_event_t ev;
  lafh_note_t note_q[$];
  lafh_pkg::lafh_event_t ev_q[$];
  int error_cnt = 0, samples_checked = 0, seed = 2139;
  always #12.5 pclk = ~pclk;
  lafh_line_model i_lafh_line_model (.pclk(pclk), .presetn(presetn), .req(req),
    .no_signal(ns), .frame_sync_missing(fs), .remote_warn_indication(rw),
    .blue_alarm_detect(bl), .voice_transition_excess(vt), .data_error_excess(de),
    .primary_clk_lost(pl), .secondary_clk_lost(sl));
  lafh_top #(.PERSIST_CYCLES(8)) i_lafh_top (.pclk(pclk), .presetn(presetn), .ce(ce),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .no_signal(ns),
    .frame_sync_missing(fs), .remote_warn_indication(rw), .blue_alarm_detect(bl),
    .error_rate(error_rate), .voice_transition_excess(vt), .data_error_excess(de),
    .primary_clk_lost(pl), .secondary_clk_lost(sl), .carrier_red_alarm(red),
    .carrier_remote_warn_alarm(warn), .trunk_cond_active(tca),
    .trunk_conditioning_setting(tcs), .tx_remote_warn(txw), .tx_ais(txa),
    .display_active(disp), .alarm_event(ev), .critical_contact(crit),
    .major_contact(maj), .cutoff_indicator(cut));
  // ==========================================================
  // apb master: request held until pready is sampled high
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      input logic [31:0] x, input logic [31:0] m, input logic e);
    note_q.push_back('{x, m, e});
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    // no cycle limit here: only the watchdog ends a wait
    while (pready !== 1'b1)
      @(posedge pclk);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : xfer
  task automatic set_al(input int i, input logic [1:0] f, input logic [1:0] s);
    cfg_v[4*i +: 4] = {s, f};
    xfer(1'b1, lafh_pkg::OFF_CFG, cfg_v, 32'h0, 32'h0, 1'b0);
  endtask : set_al
  task automatic wait_c(input int n);
    repeat (n) @(posedge pclk);
  endtask : wait_c
  // ==========================================================
  // monitors take the oldest note whenever a result shows
  always @(posedge pclk)
  begin
    if (psel && penable && pready === 1'b1 && note_q.size() > 0)
    begin
      `CHK("prdata", note_q[0].d & note_q[0].m, prdata & note_q[0].m)
      `CHK("pslverr", note_q[0].e, pslverr)
      void'(note_q.pop_front());
    end
    if (ev.valid === 1'b1 && ev_q.size() > 0 && ev_q[0].id === ev.id)
    begin
      `CHK("event", {ev_q[0].report, ev_q[0].sev}, {ev.report, ev.sev})
      void'(ev_q.pop_front());
    end
  end
  task automatic wrap_up;
    $display("checked %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : wrap_up
  initial
  begin
    wait_c(20000);
    error_cnt++;
    wrap_up();
  end
  // ==========================================================
  // scenarios
  logic [1:0] f, s;
  int idx[5] = '{2, 4, 4, 6, 6};
  initial
  begin
    cfg_v = lafh_pkg::CFG_RESET;
    wait_c(8);
    presetn <= 1'b1;
    wait_c(4);
    xfer(1'b0, lafh_pkg::OFF_STATUS, 32'h0, 32'h0000_2020, 32'h0000_FFFF, 1'b0);
    xfer(1'b0, lafh_pkg::OFF_EVENT, 32'h0, 32'h0000_0055, 32'h0000_007F, 1'b0);
    xfer(1'b0, lafh_pkg::OFF_ID, 32'h0, lafh_pkg::DEVICE_ID, 32'hFFFF_FFFF, 1'b0);
    xfer(1'b0, lafh_pkg::OFF_CFG, 32'h0, lafh_pkg::CFG_RESET, 32'hFFFF_FFFF, 1'b0);
    xfer(1'b0, lafh_pkg::OFF_THRESH, 32'h0, 32'h0000_0100, 32'h0000_FFFF, 1'b0);
    xfer(1'b0, 8'h18, 32'h0, 32'h0, 32'hFFFF_FFFF, 1'b1);
    xfer(1'b1, lafh_pkg::OFF_CTRL, 32'h0000_0008, 32'h0, 32'h0, 1'b0);
    // all filters and severities through the blue alarm, current cut-off mode
    for (int k = 0; k < 12; k++)
    begin
      f = 2'(k % 3);
      s = 2'(k / 3);
      set_al(2, f, s);
      if (f != 2'h0)
        ev_q.push_back('{1'b1, f == 2'h2, 3'h2, lafh_pkg::lafh_sev_t'(s)});
      req <= 8'h08;
      wait_c(6);
      `CHK("display2", f != 2'h0, disp[2])
      `CHK("crit", f != 2'h0 && s == 2'h3, crit)
      `CHK("major", f != 2'h0 && s == 2'h2, maj)
      `CHK("cutoff", f != 2'h0 && s == 2'h2, cut)
      req <= 8'h00;
      wait_c(6);
      `CHK("cutoff_cur", 1'b0, cut)
    end
    // filter code 3 acts as log; blue made major so the ignore check can trip
    set_al(2, 2'h3, 2'h2);
    set_al(7, 2'h0, 2'h2);
    ev_q.push_back('{1'b1, 1'b0, 3'h2, lafh_pkg::SEV_MAJOR});
    req <= 8'h08;
    wait_c(6);
    `CHK("disp_code3", 1'b1, disp[2])
    `CHK("cutoff_ign", 1'b0, cut)
    req <= 8'h00;
    set_al(7, 2'h1, 2'h2);
    xfer(1'b1, lafh_pkg::OFF_CTRL, 32'h0000_0001, 32'h0, 32'h0, 1'b0);
    req <= 8'h08;
    wait_c(6);
    req <= 8'h00;
    wait_c(8);
    `CHK("cutoff_latch", 1'b1, cut)
    xfer(1'b1, lafh_pkg::OFF_CTRL, 32'h0000_0005, 32'h0, 32'h0, 1'b0);
    wait_c(3);
    `CHK("cutoff_clr", 1'b0, cut)
    set_al(2, 2'h1, 2'h0);
    for (int j = 0; j < 5; j++)
    begin
      req <= 8'(8'h08 << j);
      wait_c(5);
      xfer(1'b0, lafh_pkg::OFF_STATUS, 32'h0, 32'(1 << (idx[j] + 8)), 32'h0000_FF00,
           1'b0);
      req <= 8'h00;
      wait_c(5);
    end
    error_rate <= 16'h0100;
    wait_c(5);
    `CHK("err_at", 1'b0, disp[3])
    error_rate <= 16'h0101 + 16'($unsigned($random(seed)) % 500);
    wait_c(5);
    `CHK("err_over", 1'b1, disp[3])
    error_rate <= 16'($unsigned($random(seed)) % 256);
    xfer(1'b1, lafh_pkg::OFF_CTRL, 32'h0000_00A2, 32'h0, 32'h0, 1'b0);
    req <= 8'h01;
    wait_c(7);
    req <= 8'h00;
    wait_c(6);
    `CHK("red_short", 1'b0, red)
    `CHK("err_low", 1'b0, disp[3])
    req <= 8'h02;
    wait_c(14);
    `CHK("red", 4'hF, {red, txw, txa, tca})
    `CHK("tc_code", 4'hA, tcs)
    // clock enable low must freeze the design although red has gone
    ce <= 1'b0;
    req <= 8'h00;
    wait_c(10);
    `CHK("ce_hold", 4'hF, {red, txw, txa, tca})
    ce <= 1'b1;
    req <= 8'h04;
    wait_c(14);
    `CHK("warn", 3'b011, {red, warn, tca})
    req <= 8'h00;
    wait_c(6);
    `CHK("ev_left", 0, ev_q.size())
    wrap_up();
  end
endmodule : lafh_top_tb
`default_nettype wire
